// *** rtl/dual_dff_pkg.sv ***
// Shared constants for the dual edge-triggered data flip-flop block
package dual_dff_pkg;

    // ************************************************************
    // Structure
    // ************************************************************
    localparam int NUM_CELLS   = 2;
    localparam int PIN_WIDTH   = 4;

    // ************************************************************
    // Field positions inside one cell's pin vector
    // ************************************************************
    localparam int PIN_CLK     = 0;
    localparam int PIN_DATA    = 1;
    localparam int PIN_SET_N   = 2;
    localparam int PIN_CLEAR_N = 3;

    // ************************************************************
    // Values after reset
    // ************************************************************
    // Clock high, data low, preset and clear released
    localparam logic [3:0] PIN_RESET_VAL   = 4'hD;
    localparam logic [1:0] STORED_RESET    = 2'h0;
    localparam logic [1:0] CLK_PREV_RESET  = 2'h3;

endpackage

// *** rtl/pin_sync.sv ***
// Three-stage pin synchroniser with a second-and-third-agree filter
`timescale 1ns/100ps

module pin_sync #(
    parameter int               WIDTH     = 4,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic [WIDTH-1:0] i_pins,
    output logic      [WIDTH-1:0] o_level
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
        logic [WIDTH-1:0] stage3;
        logic [WIDTH-1:0] level;
    } sync_state_t;

    sync_state_t state_reg;
    sync_state_t state_next;

    // Stage one feeds only stage two; the filter looks at stages two and three
    always_comb begin
        state_next        = state_reg;
        state_next.stage1 = i_pins;
        state_next.stage2 = state_reg.stage1;
        state_next.stage3 = state_reg.stage2;
        // A change counts only once stages two and three agree
        state_next.level  = (state_reg.stage2 & state_reg.stage3)
                          | (state_reg.level & (state_reg.stage2 ^ state_reg.stage3));
    end

    // Register the whole state
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_level = state_reg.level;

endmodule

// *** rtl/dual_dff.sv ***
// Two independent edge-triggered data flip-flops with preset and clear
// How it works
// - Two cells with their own clock, data, preset, clear and outputs share no state.
// - A rising edge on a cell's clock loads its data input into the true output.
// - While a cell's clock stays steady, its data input changes nothing.
// - The inverted output is the complement of the true output in clocked operation.
// - A low preset forces the true output high, and the inverted output low while clear is high.
// - A low clear with preset high forces the true output low and the inverted output high.
// - Preset and clear act at once without a clock edge and block clock edges meanwhile.
`timescale 1ns/100ps

module dual_dff (
    input  wire logic I_CLK,
    input  wire logic I_RESET,
    input  wire logic I_A_CAPTURE_CLK,
    input  wire logic I_A_DATA,
    input  wire logic I_A_SET_N,
    input  wire logic I_A_CLEAR_N,
    output logic      O_A_Q,
    output logic      O_A_Q_N,
    input  wire logic I_B_CAPTURE_CLK,
    input  wire logic I_B_DATA,
    input  wire logic I_B_SET_N,
    input  wire logic I_B_CLEAR_N,
    output logic      O_B_Q,
    output logic      O_B_Q_N
);

    // ************************************************************
    // Pin gathering and synchronisers
    // ************************************************************
    logic [dual_dff_pkg::PIN_WIDTH-1:0] cell_pins  [dual_dff_pkg::NUM_CELLS];
    logic [dual_dff_pkg::PIN_WIDTH-1:0] cell_level [dual_dff_pkg::NUM_CELLS];
    logic [dual_dff_pkg::NUM_CELLS-1:0] set_n_pin;
    logic [dual_dff_pkg::NUM_CELLS-1:0] clear_n_pin;

    // Each cell gets its own pin vector, so nothing is shared between cells
    assign cell_pins[0] = {I_A_CLEAR_N, I_A_SET_N, I_A_DATA, I_A_CAPTURE_CLK};
    assign cell_pins[1] = {I_B_CLEAR_N, I_B_SET_N, I_B_DATA, I_B_CAPTURE_CLK};
    assign set_n_pin    = {I_B_SET_N, I_A_SET_N};
    assign clear_n_pin  = {I_B_CLEAR_N, I_A_CLEAR_N};

    // Data rides the same pipeline as the clock so both stay aligned at the edge
    for (genvar c = 0; c < dual_dff_pkg::NUM_CELLS; c++) begin : g_sync
        pin_sync #(
            .WIDTH     (dual_dff_pkg::PIN_WIDTH),
            .RESET_VAL (dual_dff_pkg::PIN_RESET_VAL)
        ) u_sync (
            .i_clk   (I_CLK),
            .i_reset (I_RESET),
            .i_pins  (cell_pins[c]),
            .o_level (cell_level[c])
        );
    end

    // ************************************************************
    // Cell state
    // ************************************************************
    // One stored bit and one previous clock level per cell; the bit
    // positions keep the cells apart, nothing is mixed across them
    typedef struct packed {
        logic [dual_dff_pkg::NUM_CELLS-1:0] stored;
        logic [dual_dff_pkg::NUM_CELLS-1:0] clk_prev;
    } cell_state_t;

    cell_state_t state_reg;
    cell_state_t state_next;

    // ************************************************************
    // Filtered pin views
    // ************************************************************
    logic [dual_dff_pkg::NUM_CELLS-1:0] clk_level;
    logic [dual_dff_pkg::NUM_CELLS-1:0] data_level;
    logic [dual_dff_pkg::NUM_CELLS-1:0] set_level_n;
    logic [dual_dff_pkg::NUM_CELLS-1:0] clear_level_n;

    // Split each filtered vector into named bits so the cell logic reads plainly
    for (genvar c = 0; c < dual_dff_pkg::NUM_CELLS; c++) begin : g_view
        assign clk_level[c]     = cell_level[c][dual_dff_pkg::PIN_CLK];
        assign data_level[c]    = cell_level[c][dual_dff_pkg::PIN_DATA];
        assign set_level_n[c]   = cell_level[c][dual_dff_pkg::PIN_SET_N];
        assign clear_level_n[c] = cell_level[c][dual_dff_pkg::PIN_CLEAR_N];
    end

    // ************************************************************
    // Edge and force detection
    // ************************************************************
    logic [dual_dff_pkg::NUM_CELLS-1:0] clk_rise;
    logic [dual_dff_pkg::NUM_CELLS-1:0] set_act;
    logic [dual_dff_pkg::NUM_CELLS-1:0] clear_act;
    logic [dual_dff_pkg::NUM_CELLS-1:0] both_act;

    // Only a low-to-high change of the filtered clock is an edge; the previous
    // level resets high, so a clock already high at release is not an edge
    assign clk_rise  = clk_level & ~state_reg.clk_prev;
    // Filtered force requests, used only to steer the stored bit
    assign set_act   = ~set_level_n;
    assign clear_act = ~clear_level_n;
    assign both_act  = set_act & clear_act;

    // ************************************************************
    // Next state
    // ************************************************************
    // Preset and clear outrank any clock edge, so an edge that arrives while
    // either is held is lost instead of being applied after release
    always_comb begin
        state_next          = state_reg;
        state_next.clk_prev = clk_level;
        for (int c = 0; c < dual_dff_pkg::NUM_CELLS; c++) begin
            if (both_act[c]) begin
                // Both held: keep the old value, the outputs are forced anyway
                state_next.stored[c] = state_reg.stored[c];
            end else if (set_act[c]) begin
                state_next.stored[c] = 1'b1;
            end else if (clear_act[c]) begin
                state_next.stored[c] = 1'b0;
            end else if (clk_rise[c]) begin
                state_next.stored[c] = data_level[c];
            end else begin
                // Clock steady: the data pin has no say
                state_next.stored[c] = state_reg.stored[c];
            end
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    // Register the whole state; reset leaves both cells cleared
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            state_reg.stored   <= dual_dff_pkg::STORED_RESET;
            state_reg.clk_prev <= dual_dff_pkg::CLK_PREV_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    logic [dual_dff_pkg::NUM_CELLS-1:0] q_out;
    logic [dual_dff_pkg::NUM_CELLS-1:0] q_n_out;

    // Raw preset and clear pins override the stored bit with no clock in the
    // path, since waiting for the synchroniser would delay the forced level by
    // cycles; the price is that a glitch on those pins shows on the outputs
    always_comb begin
        q_out   = '0;
        q_n_out = '0;
        for (int c = 0; c < dual_dff_pkg::NUM_CELLS; c++) begin
            case ({set_n_pin[c], clear_n_pin[c]})
                2'h0: begin
                    // Both forced: both outputs high, stored bit not trusted
                    q_out[c]   = 1'b1;
                    q_n_out[c] = 1'b1;
                end
                2'h1: begin
                    // Preset only
                    q_out[c]   = 1'b1;
                    q_n_out[c] = 1'b0;
                end
                2'h2: begin
                    // Clear only
                    q_out[c]   = 1'b0;
                    q_n_out[c] = 1'b1;
                end
                2'h3: begin
                    // Normal operation: complementary pair from the stored bit
                    q_out[c]   = state_reg.stored[c];
                    q_n_out[c] = ~state_reg.stored[c];
                end
                default: begin
                    q_out[c]   = state_reg.stored[c];
                    q_n_out[c] = ~state_reg.stored[c];
                end
            endcase
        end
    end

    // Cell A sits on bit 0, cell B on bit 1
    assign O_A_Q   = q_out[0];
    assign O_A_Q_N = q_n_out[0];
    assign O_B_Q   = q_out[1];
    assign O_B_Q_N = q_n_out[1];

endmodule

// *** test/dual_dff_props.sv ***
// Pin checker for the dual flip-flop, bound to its top module
`timescale 1ns/100ps
module dual_dff_props (
    input wire logic I_CLK, I_RESET, O_A_Q, O_A_Q_N, O_B_Q, O_B_Q_N,
    input wire logic I_A_CAPTURE_CLK, I_A_DATA, I_A_SET_N, I_A_CLEAR_N,
    input wire logic I_B_CAPTURE_CLK, I_B_DATA, I_B_SET_N, I_B_CLEAR_N
);
    wire [1:0] qa = {O_A_Q, O_A_Q_N};
    wire [1:0] fa = {I_A_SET_N, I_A_CLEAR_N};
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_RESET);
    // Forces show in the same sample; a capture lands 5 cycles on
    a_a_set: assert property (fa == 2'h1 |-> qa == 2'h2) else $error("A set");
    a_a_clear: assert property (fa == 2'h2 |-> qa == 2'h1) else $error("A clr");
    a_a_both: assert property (fa == 2'h0 |-> qa == 2'h3) else $error("A both");
    a_a_inverse: assert property (fa == 2'h3 |-> ^qa) else $error("A inv");
    a_a_capture: assert property ($rose(I_A_CAPTURE_CLK) && fa == 2'h3 |->
        ##5 O_A_Q == $past(I_A_DATA, 5)) else $error("A cap");
    a_a_steady: assert property (
        (fa == 2'h3 && $stable(I_A_CAPTURE_CLK))[*6] |-> $stable(qa)) else $error("A hold");
    a_b_capture: assert property (
        $rose(I_B_CAPTURE_CLK) && I_B_SET_N && I_B_CLEAR_N |->
        ##5 O_B_Q == $past(I_B_DATA, 5)) else $error("B cap");
    a_b_set: assert property (
        !I_B_SET_N && I_B_CLEAR_N |-> O_B_Q && !O_B_Q_N) else $error("B set");
endmodule
bind dual_dff dual_dff_props props_u (.*);

// *** test/pin_source.sv ***
// Model of the logic driving both cells' clock, data, preset and clear
`timescale 1ns/100ps
module pin_source (
    input  wire logic       i_clk,
    output logic      [7:0] o_pins
);
    initial o_pins = 8'h33; // Per cell {clock, data, set_n, clear_n}, idle
    // Moves 1 ns after an edge and holds whole cycles, so no sample races it
    task automatic put(input logic [7:0] pins, input int hold);
        @(posedge i_clk);
        #1 o_pins = pins;
        repeat (hold - 1) @(posedge i_clk);
        #1;
    endtask
endmodule

// *** test/dual_dff_tb.sv ***
// Self-checking bench for the dual flip-flop block
`timescale 1ns/100ps
module dual_dff_tb;
    logic I_CLK = 1'h0, I_RESET = 1'h1;
    wire  [7:0] p;
    wire  [3:0] q;
    int   mismatches = 0, samples_checked = 0, cycles = 0;
    pin_source src_u (.i_clk(I_CLK), .o_pins(p));
    dual_dff dut_u (.I_CLK(I_CLK), .I_RESET(I_RESET), .I_A_CAPTURE_CLK(p[7]),
        .I_A_DATA(p[6]), .I_A_SET_N(p[5]), .I_A_CLEAR_N(p[4]), .O_A_Q(q[3]),
        .O_A_Q_N(q[2]), .I_B_CAPTURE_CLK(p[3]), .I_B_DATA(p[2]), .I_B_SET_N(p[1]),
        .I_B_CLEAR_N(p[0]), .O_B_Q(q[1]), .O_B_Q_N(q[0]));
    // Clock, and a hang limit far above the 65 cycles needed
    initial forever #2 I_CLK = ~I_CLK;
    always @(posedge I_CLK) begin
        cycles++;
        if (cycles == 1000) mismatches++;
        if (cycles == 1000) close_out();
    end
    task automatic check(input logic [3:0] seen, exp);
        samples_checked++;
        mismatches += (seen !== exp);
        if (seen !== exp) $display("MISMATCH %0t: saw %h want %h", $time, seen, exp);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Opposite data into the cells shows they share no state
    task automatic test_capture();
        logic d = 1'h1;
        repeat (3) begin
            src_u.put({1'h0, d, 2'h3, 1'h0, ~d, 2'h3}, 4);
            src_u.put({1'h1, d, 2'h3, 1'h1, ~d, 2'h3}, 8);
            check(q, {d, ~d, ~d, d});
            d = ~d;
        end
        $display("capture test done");
    endtask
    // Edges while forced must be lost, so release with clock high
    task automatic test_force();
        src_u.put(8'h21, 1);
        check(q, 4'h6);
        src_u.put(8'hE9, 8);
        src_u.put(8'hFB, 8);
        check(q, 4'h6);
        src_u.put(8'hCB, 8);
        check(q, 4'hE);
        $display("force test done");
    endtask
    initial begin
        #17 I_RESET = 1'h0; // Held 4 cycles
        test_capture();
        test_force();
        close_out();
    end
endmodule
